// File: logic/brd_pkg.sv
// package for the baud rate detector: register map, field layout, reset values, timing counts
// assumes a 32-bit classic wishbone slave, one word per register
package brd_pkg;
	localparam logic [7:0] BRD_START_IDX     = 8'h10;
	localparam logic [7:0] BRD_LOWER_IDX     = 8'h11;
	localparam logic [7:0] BRD_UPPER_IDX     = 8'h12;
	localparam logic [7:0] BRD_CTRL_IDX      = 8'h20;
	localparam logic [7:0] BRD_TIMER_IDX     = 8'h21;
	localparam logic [7:0] BRD_STATUS_IDX    = 8'h22;
	localparam int         BRD_FIELD_W       = 6;
	localparam logic [5:0] BRD_LIMIT_RST     = 6'h00;
	localparam logic [5:0] BRD_TIMER_INIT_RST = 6'h3f;
	localparam logic [4:0] BRD_CNT_TOP       = 5'd29;
	localparam logic [4:0] BRD_CNT_WRAP      = 5'd10;
	localparam logic [5:0] BRD_DIV_TIMER     = 6'd20;
	localparam int         BRD_CTRL_HALVE_BIT = 0;
	localparam int         BRD_CTRL_RELOAD_BIT = 1;
	localparam logic [7:0] BRD_PASS_RST      = 8'h00;

	typedef struct packed {
		logic       pass;
		logic       fail;
		logic       rise;
	} brd_result_s;
endpackage

// File: logic/brd_top.sv
// baud rate detector: like-transition spacing checker with diversity-timer start compare
// assumes rx_data synchronous to clock; software on classic wishbone, 32-bit data
//
// Behaviour
// - The test starts once the diversity timer equals the programmed start value.
// - The diversity timer counts down from a separately programmed initial value.
// - The diversity timer keeps running even when automatic diversity is off.
// - The timer steps every 20 clocks, or every 40 clocks with clock halving.
// - A like-transition spacing below the lower bound fails the test.
// - Rising and falling spacings use two separate identical counters.
// - Each counter counts up from zero and wraps from 29 to 10.
// - Counters step each clock, or every second clock with clock halving.
// - A like-transition spacing above the upper bound fails the test.
// - The pass count clears whenever the antenna selection changes.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module brd_top
	import brd_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic             rx_data,
	input  wire logic             antenna_select,
	output logic                  detect_active,
	output brd_pkg::brd_result_s  test_result
);
	import brd_pkg::*;

	logic       rst_s1_r, rst_s2_r;
	logic [5:0] detect_start_value_r, spacing_lower_bound_r, spacing_upper_bound_r;
	logic [5:0] timer_init_r, div_timer_r, timer_r;
	logic       clock_halving_select_r, reload_r, half_r, rx_prev_r, ant_prev_r;
	logic [4:0] rise_cnt_r, fall_cnt_r;
	logic [7:0] pass_cnt_r;
	logic       active_r, ack_r;
	logic [31:0] dat_r;
	brd_result_s res_r;

	// reset released through two flops
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_i_n = rst_s2_r;

	function automatic logic [4:0] brd_step(input logic [4:0] c);
		brd_step = (c == BRD_CNT_TOP) ? BRD_CNT_WRAP : c + 5'd1;
	endfunction

	// wishbone decode; one-cycle answer, ack drops after each beat
	// read data is captured on the request edge, a write lands on the acked edge
	wire req      = wb_cyc_i && wb_stb_i && !ack_r;
	wire beat     = wb_cyc_i && wb_stb_i && ack_r;
	wire wr_lo    = beat && wb_we_i && wb_sel_i[0];
	wire [7:0] idx = {2'b00, wb_adr_i[7:2]};
	wire wr_start = wr_lo && (idx == BRD_START_IDX);
	wire wr_lower = wr_lo && (idx == BRD_LOWER_IDX);
	wire wr_upper = wr_lo && (idx == BRD_UPPER_IDX);
	wire wr_ctrl  = wr_lo && (idx == BRD_CTRL_IDX);
	wire wr_timer = wr_lo && (idx == BRD_TIMER_IDX);
	wire [31:0] rd_mux =
		(idx == BRD_START_IDX)  ? {26'h0, detect_start_value_r} :
		(idx == BRD_LOWER_IDX)  ? {26'h0, spacing_lower_bound_r} :
		(idx == BRD_UPPER_IDX)  ? {26'h0, spacing_upper_bound_r} :
		(idx == BRD_CTRL_IDX)   ? {30'h0, reload_r, clock_halving_select_r} :
		(idx == BRD_TIMER_IDX)  ? {18'h0, timer_r, 2'b00, timer_init_r} :
		(idx == BRD_STATUS_IDX) ? {23'h0, active_r, pass_cnt_r} : 32'h0;

	// timing ticks
	wire timer_tick = (div_timer_r == BRD_DIV_TIMER - 6'd1) && (!clock_halving_select_r || half_r);
	wire baud_tick  = !clock_halving_select_r || half_r;
	wire rise_edge  = rx_data && !rx_prev_r;
	wire fall_edge  = !rx_data && rx_prev_r;
	wire start_hit  = (timer_r == detect_start_value_r);
	wire [4:0] meas = rise_edge ? rise_cnt_r : fall_cnt_r;
	wire in_range   = ({1'b0, meas} >= spacing_lower_bound_r) &&
	                  ({1'b0, meas} <= spacing_upper_bound_r);
	wire tested     = active_r && (rise_edge || fall_edge);
	wire ant_change = antenna_select != ant_prev_r;
	// the edge cycle's own tick counts, so a spacing of n ticks reads n
	wire [4:0] restart_cnt = baud_tick ? 5'd1 : 5'd0;

	always_ff @(posedge clock or negedge rst_i_n)
	begin
		if (!rst_i_n)
		begin
			detect_start_value_r   <= BRD_LIMIT_RST;
			spacing_lower_bound_r  <= BRD_LIMIT_RST;
			spacing_upper_bound_r  <= BRD_LIMIT_RST;
			clock_halving_select_r <= 1'b0;
			reload_r               <= 1'b0;
			timer_init_r           <= BRD_TIMER_INIT_RST;
			ack_r                  <= 1'b0;
			dat_r                  <= 32'h0;
		end
		else
		begin
			ack_r <= req;
			if (req)
				dat_r <= rd_mux;
			// reserved bits 7:6 are dropped
			if (wr_start)
				detect_start_value_r <= wb_dat_i[5:0];
			if (wr_lower)
				spacing_lower_bound_r <= wb_dat_i[5:0];
			if (wr_upper)
				spacing_upper_bound_r <= wb_dat_i[5:0];
			if (wr_ctrl)
			begin
				clock_halving_select_r <= wb_dat_i[BRD_CTRL_HALVE_BIT];
				reload_r               <= wb_dat_i[BRD_CTRL_RELOAD_BIT];
			end
			if (wr_timer)
				timer_init_r <= wb_dat_i[5:0];
		end
	end

	always_ff @(posedge clock or negedge rst_i_n)
	begin
		if (!rst_i_n)
		begin
			half_r      <= 1'b0;
			div_timer_r <= 6'h00;
			timer_r     <= BRD_TIMER_INIT_RST;
			active_r    <= 1'b0;
		end
		else
		begin
			half_r <= !half_r;
			if (!clock_halving_select_r || half_r)
				div_timer_r <= timer_tick ? 6'h00 : div_timer_r + 6'd1;
			// free running: never gated by diversity enable, reloads from initial value
			if (ant_change || (reload_r && timer_r == 6'h00 && timer_tick))
				timer_r <= timer_init_r;
			else if (timer_tick)
				timer_r <= timer_r - 6'd1;
			if (ant_change)
				active_r <= 1'b0;
			else if (start_hit)
				active_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_i_n)
	begin
		if (!rst_i_n)
		begin
			rx_prev_r  <= 1'b0;
			ant_prev_r <= 1'b0;
			rise_cnt_r <= 5'd0;
			fall_cnt_r <= 5'd0;
			pass_cnt_r <= BRD_PASS_RST;
			res_r      <= '0;
		end
		else
		begin
			rx_prev_r  <= rx_data;
			ant_prev_r <= antenna_select;
			if (rise_edge)
				rise_cnt_r <= restart_cnt;
			else if (baud_tick)
				rise_cnt_r <= brd_step(rise_cnt_r);
			if (fall_edge)
				fall_cnt_r <= restart_cnt;
			else if (baud_tick)
				fall_cnt_r <= brd_step(fall_cnt_r);
			res_r.pass <= tested && in_range;
			res_r.fail <= tested && !in_range;
			res_r.rise <= tested ? rise_edge : res_r.rise;
			if (ant_change)
				pass_cnt_r <= BRD_PASS_RST;
			else if (tested && in_range && pass_cnt_r != 8'hff)
				pass_cnt_r <= pass_cnt_r + 8'd1;
		end
	end

	assign wb_ack_o      = ack_r;
	assign wb_dat_o      = dat_r;
	assign detect_active = active_r;
	assign test_result   = res_r;

	sequence wrap_top_s;
		baud_tick && !rise_edge && rise_cnt_r == BRD_CNT_TOP;
	endsequence
	counter_wrap_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		wrap_top_s |=> rise_cnt_r == BRD_CNT_WRAP)
		else $error("rise counter did not wrap to ten");
	counter_restart_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		fall_edge |=> fall_cnt_r == {4'h0, $past(baud_tick)})
		else $error("fall counter not restarted");
	lower_fail_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(tested && {1'b0, meas} < spacing_lower_bound_r) |=> res_r.fail && !res_r.pass)
		else $error("short spacing not failed");
	upper_fail_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(tested && {1'b0, meas} > spacing_upper_bound_r) |=> res_r.fail)
		else $error("long spacing not failed");
	start_compare_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(start_hit && !ant_change) |=> detect_active)
		else $error("test not started on compare");
	pass_clear_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		ant_change |=> pass_cnt_r == 8'h00)
		else $error("pass count not cleared");
	timer_step_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(timer_tick && !ant_change && !reload_r && timer_r != 6'h00) |=>
		timer_r == $past(timer_r) - 6'd1)
		else $error("diversity timer did not step");
	timer_gap_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(timer_tick && !clock_halving_select_r && !wr_ctrl) |=> !timer_tick [*8])
		else $error("timer ticks too close");
	halve_rate_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(clock_halving_select_r && !wr_ctrl && baud_tick) |=> !baud_tick)
		else $error("counter stepped too fast");
	counter_hold_a: assert property (@(posedge clock) disable iff (!rst_i_n)
		(!baud_tick && !rise_edge) |=> rise_cnt_r == $past(rise_cnt_r))
		else $error("counter moved without a baud tick");
endmodule

// File: tb/brd_rx_model.sv
// partner: transceiver receive data, a square wave of a given period in clocks
// assumes period 0 means an idle line held at its last level
`timescale 1ns/1ns
module brd_rx_model
(
	input  wire logic       clock,
	input  wire logic [7:0] period,
	output logic            rx
);
	logic [7:0] cnt_r;
	initial rx = 1'b0;
	initial cnt_r = 8'h00;
	always @(posedge clock)
	begin
		if (period != 8'h00)
		begin
			cnt_r <= (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
			rx <= (cnt_r < period / 2);
		end
	end
endmodule

// File: tb/baud_rate_detector_tb.sv
// bench: register bus, start compare, spacing pass and fail, antenna clear
// assumes brd_pkg, brd_top and brd_rx_model compiled first
`timescale 1ns/1ns
module baud_rate_detector_tb;
	import brd_pkg::*;
	logic        clock, rst_n, cyc, stb, we, ant, ack, rx, act;
	logic [7:0]  adr, per;
	logic [31:0] dat, rd, wdo, t0;
	brd_result_s res;
	int          err_count, checks, seed, i, d, npass;
	logic        q[$];
	brd_top DUT (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
		.rx_data(rx), .antenna_select(ant), .detect_active(act), .test_result(res));
	brd_rx_model PHY (.clock(clock), .period(per), .rx(rx));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (e !== g)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] ix, input logic [31:0] v);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix[5:0], 2'b00};
		dat <= v;
		i = 0;
		@(posedge clock);
		while (ack !== 1'b1 && i++ < 50) @(posedge clock);
		chk("ack", 32'h1, {31'h0, ack});
		rd = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [7:0] ix, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, ix, 32'h0);
		chk(nm, e, rd & m);
	endtask
	// idle line only: a pass judged here could reach npass after the pass count clears
	task flip;
		ant <= ~ant;
		npass = 0;
		repeat (35) @(posedge clock);
		chk("idle", 1'b0, act);
		for (i = 0; i < 150 && act !== 1'b1; i++) @(posedge clock);
		chk("active", 1'b1, act);
	endtask
	// timer read twice; a gap of n clocks should show 20 steps
	task tdiff(input int n);
		bus(1'b0, BRD_TIMER_IDX, 32'h0);
		t0 = rd;
		repeat (n) @(posedge clock);
		bus(1'b0, BRD_TIMER_IDX, 32'h0);
		d = (t0[13:8] - rd[13:8]) & 6'h3f;
		chk("timer", 1'b1, d >= 19 && d <= 21);
	endtask
	// first pairs after a period change are not judged, so results are noted late
	task run(input logic [7:0] p, input logic e);
		per <= p;
		repeat (3 * p) @(posedge clock);
		repeat (4) q.push_back(e);
		for (i = 0; i < 300 && q.size() != 0; i++) @(posedge clock);
		chk("pending", 0, q.size());
		$display("spacing %0d done", p);
	endtask
	// rx still shows the level of the judged edge: every half period is 5 clocks or more
	always @(posedge clock)
	begin
		if (res.pass === 1'b1)
			npass++;
		if ((res.pass | res.fail) === 1'b1 && q.size() != 0)
		begin
			chk("result", {31'h0, q.pop_front()}, {31'h0, res.pass});
			chk("edge", {31'h0, rx}, {31'h0, res.rise});
		end
	end
	task end_of_test;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_of_test;
	end
	initial
	begin
		seed = 32'h7d85c265;
		err_count = 0;
		checks = 0;
		npass = 0;
		{rst_n, cyc, stb, we, ant} = 5'h00;
		adr = 8'h00;
		per = 8'h00;
		dat = 32'h0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rdchk("start", BRD_START_IDX, 32'h3f, 32'h0);
		rdchk("lower", BRD_LOWER_IDX, 32'h3f, 32'h0);
		rdchk("upper", BRD_UPPER_IDX, 32'h3f, 32'h0);
		rdchk("tinit", BRD_TIMER_IDX, 32'h3f, 32'h3f);
		bus(1'b1, 8'h3f, 32'h2a);
		rdchk("unmapped", 8'h3f, 32'hffffffff, 32'h0);
		bus(1'b1, BRD_START_IDX, 32'h3c);
		bus(1'b1, BRD_LOWER_IDX, 32'h12);
		bus(1'b1, BRD_UPPER_IDX, 32'h16);
		rdchk("lower", BRD_LOWER_IDX, 32'h3f, 32'h12);
		$display("registers done");
		flip;
		tdiff(400);
		run(8'(19 + $unsigned($random(seed)) % 3), 1'b1);
		run(40, 1'b1);
		run(10, 1'b0);
		run(26, 1'b0);
		per <= 8'h0;
		bus(1'b0, BRD_STATUS_IDX, 32'h0);
		chk("passes", (npass > 255) ? 32'hff : npass, rd & 32'hff);
		chk("counted", 1'b1, rd[7:0] != 8'h0);
		flip;
		rdchk("cleared", BRD_STATUS_IDX, 32'hff, 32'h0);
		bus(1'b1, BRD_CTRL_IDX, 32'h1);
		tdiff(800);
		flip;
		run(40, 1'b1);
		run(20, 1'b0);
		end_of_test;
	end
endmodule
